// ==== orx_params.svh ====
// Offsets, field positions, command and read-back values and constants of the receive lower management map
`ifndef ORX_PARAMS_SVH
`define ORX_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (lower 128 bytes)
// ----------------------------------------------------------------------
`define ORX_OFF_PAGING      8'h02
`define ORX_OFF_SUMMARY     8'h06
`define ORX_OFF_LOS_HI      8'h07
`define ORX_OFF_LOS_LO      8'h08
`define ORX_OFF_TEMP_LATCH  8'h11
`define ORX_OFF_SUP_LATCH   8'h12
`define ORX_OFF_TEMP_MON    8'h16
`define ORX_OFF_SUP_MON_HI  8'h1a
`define ORX_OFF_SUP_MON_LO  8'h1b
`define ORX_OFF_ELAPSED_HI  8'h26
`define ORX_OFF_ELAPSED_LO  8'h27
`define ORX_OFF_HIGH_POWER  8'h2a
`define ORX_OFF_SOFT_RESET  8'h33
`define ORX_OFF_CHDIS_HI    8'h34
`define ORX_OFF_CHDIS_LO    8'h35
`define ORX_OFF_OUTDIS_HI   8'h36
`define ORX_OFF_OUTDIS_LO   8'h37
`define ORX_OFF_LOSMASK_HI  8'h5f
`define ORX_OFF_LOSMASK_LO  8'h60
`define ORX_OFF_TEMP_MASK   8'h69
`define ORX_OFF_SUP_MASK    8'h6a
`define ORX_OFF_EEPROM_VER  8'h6e
`define ORX_OFF_FW_FIRST    8'h6f
`define ORX_OFF_FW_LAST     8'h74
`define ORX_OFF_PW_FIRST    8'h77
`define ORX_OFF_PW_LAST     8'h7e
`define ORX_OFF_PAGE_SEL    8'h7f
`define ORX_UPPER_BASE      8'h80

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ORX_CAP_PAGE02_BIT  4
`define ORX_CAP_ALTADDR_BIT 3
`define ORX_CAP_PAGING_BIT  2
`define ORX_CAP_INT_BIT     1
`define ORX_CAP_NRDY_BIT    0
`define ORX_SUM_LOS_BIT     6
`define ORX_SUM_MODULE_BIT  1
`define ORX_ALARM_HI_BIT    7
`define ORX_ALARM_LO_BIT    6

// ----------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------
`define ORX_SOFT_RESET_CMD  8'h01
`define ORX_RESERVED_READ   8'h00
`define ORX_UPPER_READ      8'hff
`define ORX_EEPROM_VER_VAL  8'h01
`define ORX_FW_INFO_VAL     48'h0102_0304_0506

`endif

// ==== orx_pkg.sv ====
// Types shared by the receive lower management map
package orx_pkg;
   typedef logic [7:0]  orx_byte_t;
   typedef logic [11:0] orx_chan_t;
   typedef logic [1:0]  orx_alarm_t;
endpackage : orx_pkg

// ==== orx_lower_map.sv ====
// Lower 128-byte management register space of a 12-channel optical receiver
`timescale 1ns/10ps
`include "orx_params.svh"

module orx_lower_map #(
   parameter logic [7:0]  EEPROM_VERSION = `ORX_EEPROM_VER_VAL, // Arbitrary value
   parameter logic [47:0] FIRMWARE_INFO  = `ORX_FW_INFO_VAL     // Arbitrary value
) (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              arst_n,
   // Byte access from the two-wire serial engine
   input  wire logic [7:0]        reg_addr,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [7:0]        reg_wdata,
   output      logic [7:0]        reg_rdata,
   output      logic              reg_rvalid,
   // Optical engine status and monitors
   input  wire logic [11:0]       signal_loss,
   input  wire logic              temp_high_cond,
   input  wire logic              temp_low_cond,
   input  wire logic              supply_high_cond,
   input  wire logic              supply_low_cond,
   input  wire logic              engine_ready,
   input  wire logic [7:0]        temp_value,
   input  wire logic [15:0]       supply_value,
   input  wire logic [15:0]       elapsed_time,
   // Controls and interrupt
   output      logic              irq_pin_n,
   output      logic [7:0]        upper_page,
   output      logic              high_power_sel,
   output      logic [11:0]       channel_disable,
   output      logic [11:0]       output_disable
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic orx_pkg::orx_byte_t hi_part(input logic [15:0] v);
      hi_part = v[15:8];
   endfunction : hi_part
   function automatic orx_pkg::orx_byte_t chan_hi(input orx_pkg::orx_chan_t v);
      chan_hi = {4'h0, v[11:8]};
   endfunction : chan_hi
   function automatic orx_pkg::orx_byte_t alarm_byte(input orx_pkg::orx_alarm_t v);
      alarm_byte = {v, 6'h00};
   endfunction : alarm_byte

   // ----------------------------------------------------------------------
   // Pin synchroniser for signal loss
   // ----------------------------------------------------------------------
   orx_pkg::orx_chan_t los_s1;
   orx_pkg::orx_chan_t los_s2;
   orx_pkg::orx_chan_t los_s3;
   orx_pkg::orx_chan_t los_cond;
   orx_pkg::orx_chan_t next_los_cond;
   always_comb begin
      // Only bits on which the second and third stages agree take a new value
      next_los_cond = (los_s2 & los_s3) | (los_cond & (los_s2 ^ los_s3));
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         los_s1   <= 12'h000;
         los_s2   <= 12'h000;
         los_s3   <= 12'h000;
         los_cond <= 12'h000;
      end else begin
         los_s1   <= signal_loss;
         los_s2   <= los_s1;
         los_s3   <= los_s2;
         los_cond <= next_los_cond;
      end
   end

   // ----------------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------------
   logic rd_lo;
   logic wr_lo;
   logic soft_rst;
   assign rd_lo    = reg_rd && (reg_addr < `ORX_UPPER_BASE);
   // Read wins over a simultaneous write; the write is dropped
   assign wr_lo    = reg_wr && !reg_rd && (reg_addr < `ORX_UPPER_BASE);
   assign soft_rst = wr_lo && (reg_addr == `ORX_OFF_SOFT_RESET)
                     && (reg_wdata == `ORX_SOFT_RESET_CMD);

   // ----------------------------------------------------------------------
   // Latched flags and interrupt
   // ----------------------------------------------------------------------
   orx_pkg::orx_chan_t  los_flags;
   orx_pkg::orx_alarm_t temp_flags;
   orx_pkg::orx_alarm_t sup_flags;
   orx_pkg::orx_chan_t  next_los_flags;
   orx_pkg::orx_alarm_t next_temp_flags;
   orx_pkg::orx_alarm_t next_sup_flags;
   orx_pkg::orx_chan_t  los_clr;
   logic                temp_clr;
   logic                sup_clr;
   logic                not_ready;
   logic                next_not_ready;
   logic                next_irq_n;
   logic                irq_any;
   orx_pkg::orx_chan_t  los_mask;
   orx_pkg::orx_alarm_t temp_mask;
   orx_pkg::orx_alarm_t sup_mask;
   always_comb begin
      los_clr[11:8] = {4{rd_lo && reg_addr == `ORX_OFF_LOS_HI}};
      los_clr[7:0]  = {8{rd_lo && reg_addr == `ORX_OFF_LOS_LO}};
      temp_clr = rd_lo && (reg_addr == `ORX_OFF_TEMP_LATCH);
      sup_clr  = rd_lo && (reg_addr == `ORX_OFF_SUP_LATCH);
      // A live condition sets the flag even in the clearing cycle
      next_los_flags  = ((soft_rst ? 12'h000 : los_flags) & ~los_clr) | los_cond;
      next_temp_flags = ((soft_rst || temp_clr) ? 2'b00 : temp_flags)
                        | {temp_high_cond, temp_low_cond};
      next_sup_flags  = ((soft_rst || sup_clr) ? 2'b00 : sup_flags)
                        | {supply_high_cond, supply_low_cond};
      // Ready is a one-way drop: it never returns high without a pin reset
      next_not_ready  = not_ready && !engine_ready;
      irq_any = |(los_flags & ~los_mask) | |(temp_flags & ~temp_mask)
                | |(sup_flags & ~sup_mask);
      next_irq_n = !irq_any;
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         los_flags  <= 12'h000;
         temp_flags <= 2'b00;
         sup_flags  <= 2'b00;
         not_ready  <= 1'b1;
         irq_pin_n  <= 1'b1;
      end else begin
         los_flags  <= next_los_flags;
         temp_flags <= next_temp_flags;
         sup_flags  <= next_sup_flags;
         not_ready  <= next_not_ready;
         irq_pin_n  <= next_irq_n;
      end
   end

   // ----------------------------------------------------------------------
   // Writable registers
   // ----------------------------------------------------------------------
   orx_pkg::orx_chan_t  next_los_mask;
   orx_pkg::orx_alarm_t next_temp_mask;
   orx_pkg::orx_alarm_t next_sup_mask;
   orx_pkg::orx_byte_t  high_power;
   orx_pkg::orx_byte_t  next_high_power;
   orx_pkg::orx_chan_t  next_chdis;
   orx_pkg::orx_chan_t  next_outdis;
   orx_pkg::orx_byte_t  next_page;
   orx_pkg::orx_byte_t  pw [0:7];
   orx_pkg::orx_byte_t  next_pw [0:7];
   always_comb begin
      next_los_mask   = los_mask;
      next_temp_mask  = temp_mask;
      next_sup_mask   = sup_mask;
      next_high_power = high_power;
      next_chdis      = channel_disable;
      next_outdis     = output_disable;
      next_page       = upper_page;
      next_pw         = pw;
      if (soft_rst) begin
         next_los_mask   = 12'h000;
         next_temp_mask  = 2'b00;
         next_sup_mask   = 2'b00;
         next_high_power = 8'h00;
         next_chdis      = 12'h000;
         next_outdis     = 12'h000;
         next_page       = 8'h00;
         next_pw         = '{default: 8'h00};
      end else if (wr_lo) begin
         // Unlisted offsets fall through: read-only and reserved bytes keep state
         case (reg_addr)
            `ORX_OFF_LOSMASK_HI: next_los_mask[11:8] = reg_wdata[3:0];
            `ORX_OFF_LOSMASK_LO: next_los_mask[7:0]  = reg_wdata;
            `ORX_OFF_TEMP_MASK:  next_temp_mask      = reg_wdata[7:6];
            `ORX_OFF_SUP_MASK:   next_sup_mask       = reg_wdata[7:6];
            `ORX_OFF_HIGH_POWER: next_high_power     = reg_wdata;
            `ORX_OFF_CHDIS_HI:   next_chdis[11:8]    = reg_wdata[3:0];
            `ORX_OFF_CHDIS_LO:   next_chdis[7:0]     = reg_wdata;
            `ORX_OFF_OUTDIS_HI:  next_outdis[11:8]   = reg_wdata[3:0];
            `ORX_OFF_OUTDIS_LO:  next_outdis[7:0]    = reg_wdata;
            `ORX_OFF_PAGE_SEL:   next_page           = reg_wdata;
            default: begin
               if (reg_addr >= `ORX_OFF_PW_FIRST && reg_addr <= `ORX_OFF_PW_LAST) begin
                  next_pw[3'(reg_addr - `ORX_OFF_PW_FIRST)] = reg_wdata;
               end
            end
         endcase
      end
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         los_mask        <= 12'h000;
         temp_mask       <= 2'b00;
         sup_mask        <= 2'b00;
         high_power      <= 8'h00;
         channel_disable <= 12'h000;
         output_disable  <= 12'h000;
         upper_page      <= 8'h00;
         pw              <= '{default: 8'h00};
      end else begin
         los_mask        <= next_los_mask;
         temp_mask       <= next_temp_mask;
         sup_mask        <= next_sup_mask;
         high_power      <= next_high_power;
         channel_disable <= next_chdis;
         output_disable  <= next_outdis;
         upper_page      <= next_page;
         pw              <= next_pw;
      end
   end
   assign high_power_sel = high_power[0];

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   orx_pkg::orx_byte_t rd_byte;
   orx_pkg::orx_byte_t next_rdata;
   orx_pkg::orx_byte_t cap_byte;
   orx_pkg::orx_byte_t sum_byte;
   always_comb begin
      cap_byte = 8'h00;
      cap_byte[`ORX_CAP_PAGE02_BIT]  = 1'b1;
      cap_byte[`ORX_CAP_ALTADDR_BIT] = 1'b0;
      cap_byte[`ORX_CAP_PAGING_BIT]  = 1'b1;
      cap_byte[`ORX_CAP_INT_BIT]     = !irq_pin_n;
      cap_byte[`ORX_CAP_NRDY_BIT]    = not_ready;
      sum_byte = 8'h00;
      sum_byte[`ORX_SUM_LOS_BIT]    = |los_flags;
      sum_byte[`ORX_SUM_MODULE_BIT] = |temp_flags || |sup_flags;
      rd_byte = `ORX_RESERVED_READ;
      // Lower region decodes on address alone, page select never gates it
      if (reg_addr >= `ORX_UPPER_BASE) begin
         rd_byte = `ORX_UPPER_READ;
      end else begin
         case (reg_addr)
            `ORX_OFF_PAGING:     rd_byte = cap_byte;
            `ORX_OFF_SUMMARY:    rd_byte = sum_byte;
            `ORX_OFF_LOS_HI:     rd_byte = chan_hi(los_flags);
            `ORX_OFF_LOS_LO:     rd_byte = los_flags[7:0];
            `ORX_OFF_TEMP_LATCH: rd_byte = alarm_byte(temp_flags);
            `ORX_OFF_SUP_LATCH:  rd_byte = alarm_byte(sup_flags);
            `ORX_OFF_TEMP_MON:   rd_byte = temp_value;
            `ORX_OFF_SUP_MON_HI: rd_byte = hi_part(supply_value);
            `ORX_OFF_SUP_MON_LO: rd_byte = supply_value[7:0];
            `ORX_OFF_ELAPSED_HI: rd_byte = hi_part(elapsed_time);
            `ORX_OFF_ELAPSED_LO: rd_byte = elapsed_time[7:0];
            `ORX_OFF_HIGH_POWER: rd_byte = high_power;
            `ORX_OFF_CHDIS_HI:   rd_byte = chan_hi(channel_disable);
            `ORX_OFF_CHDIS_LO:   rd_byte = channel_disable[7:0];
            `ORX_OFF_OUTDIS_HI:  rd_byte = chan_hi(output_disable);
            `ORX_OFF_OUTDIS_LO:  rd_byte = output_disable[7:0];
            `ORX_OFF_LOSMASK_HI: rd_byte = chan_hi(los_mask);
            `ORX_OFF_LOSMASK_LO: rd_byte = los_mask[7:0];
            `ORX_OFF_TEMP_MASK:  rd_byte = alarm_byte(temp_mask);
            `ORX_OFF_SUP_MASK:   rd_byte = alarm_byte(sup_mask);
            `ORX_OFF_EEPROM_VER: rd_byte = EEPROM_VERSION;
            `ORX_OFF_PAGE_SEL:   rd_byte = upper_page;
            default: begin
               if (reg_addr >= `ORX_OFF_FW_FIRST && reg_addr <= `ORX_OFF_FW_LAST) begin
                  rd_byte = FIRMWARE_INFO[8 * (3'(`ORX_OFF_FW_LAST - reg_addr)) +: 8];
               end else if (reg_addr >= `ORX_OFF_PW_FIRST && reg_addr <= `ORX_OFF_PW_LAST) begin
                  rd_byte = pw[3'(reg_addr - `ORX_OFF_PW_FIRST)];
               end
            end
         endcase
      end
      next_rdata = reg_rd ? rd_byte : reg_rdata;
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata  <= next_rdata;
         reg_rvalid <= reg_rd;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence s_los_read;
      reg_rd && reg_addr == `ORX_OFF_LOS_LO;
   endsequence
   sequence s_snapshot_back(logic [7:0] held);
      reg_rvalid && reg_rdata == held;
   endsequence

   a_read_snapshot: assert property (s_los_read |=> s_snapshot_back($past(los_flags[7:0])))
      else $error("flag read did not return the held value");
   a_set_wins_clear: assert property (s_los_read and los_cond[0] |=> los_flags[0])
      else $error("event lost during clearing read");
   a_flag_sticky: assert property (los_flags[3] && !los_clr[3] && !soft_rst |=> los_flags[3])
      else $error("latched flag dropped without a read");
   a_irq_unmasked: assert property (temp_flags[1] && !temp_mask[1]
                                    |=> !irq_pin_n && cap_byte[`ORX_CAP_INT_BIT])
      else $error("unmasked flag did not assert interrupt");
   a_irq_idle: assert property (los_flags == 12'h000 && temp_flags == 2'b00
                                && sup_flags == 2'b00 |=> irq_pin_n)
      else $error("interrupt asserted with no flags");
   a_ready_drop: assert property (not_ready && engine_ready |=> !not_ready [*2])
      else $error("not-ready bit failed to drop");
   a_summary_los: assert property (reg_rd && reg_addr == `ORX_OFF_SUMMARY
                                   |=> reg_rdata[`ORX_SUM_LOS_BIT] == $past(|los_flags))
      else $error("signal loss summary wrong");
   a_soft_reset: assert property (soft_rst |=> los_mask == 12'h000 && upper_page == 8'h00)
      else $error("soft reset left registers set");
   a_page_write: assert property (wr_lo && reg_addr == `ORX_OFF_PAGE_SEL && !soft_rst
                                  |=> upper_page == $past(reg_wdata))
      else $error("page select not stored");
   a_ro_ignored: assert property (wr_lo && reg_addr == `ORX_OFF_PAGING
                                  |=> $stable(los_mask) && $stable(upper_page))
      else $error("read-only write disturbed state");

endmodule : orx_lower_map

// ==== orx_host_model.sv ====
// Host management master model driving the byte access port
`timescale 1ns/10ps
module orx_host_model (
   // Clock
   input  wire logic       mclk,
   // Byte access port
   output      logic [7:0] reg_addr,
   output      logic       reg_wr,
   output      logic       reg_rd,
   output      logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 8'h00;
   end
   // Data bus is inverted after the write so a stale byte never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(negedge mclk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr
   // The valid strobe stands for one cycle only, so the answer is taken at the next falling edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(negedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(negedge mclk);
      reg_rd <= 1'b0;
      d  = reg_rdata;
      ok = reg_rvalid;
   endtask : rd
endmodule : orx_host_model

// ==== orx_lower_map_tb.sv ====
// Self-checking bench for the receive lower management map
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
   tests_run++; \
   if ((g) !== (e)) begin \
      bad_count++; \
      $display("wrong value %s expected %h seen %h", n, e, g); \
   end \
end
module orx_lower_map_tb;
   logic        mclk, arst_n, reg_wr, reg_rd, reg_rvalid, irq_pin_n, high_power_sel;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, upper_page, temp_value, k;
   logic [11:0] signal_loss, channel_disable, output_disable;
   logic        temp_high_cond, temp_low_cond, supply_high_cond, supply_low_cond;
   logic        engine_ready;
   logic [15:0] supply_value, elapsed_time;
   int          bad_count, tests_run, cycles;

   orx_lower_map i_orx_lower_map (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .signal_loss(signal_loss), .temp_high_cond(temp_high_cond),
      .temp_low_cond(temp_low_cond), .supply_high_cond(supply_high_cond),
      .supply_low_cond(supply_low_cond), .engine_ready(engine_ready),
      .temp_value(temp_value), .supply_value(supply_value), .elapsed_time(elapsed_time),
      .irq_pin_n(irq_pin_n), .upper_page(upper_page), .high_power_sel(high_power_sel),
      .channel_disable(channel_disable), .output_disable(output_disable));
   orx_host_model i_orx_host_model (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));

   // ----------------------------------------------------------------------
   // Shared steps
   // ----------------------------------------------------------------------
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       ok;
      i_orx_host_model.rd(a, d, ok);
      `CHK($sformatf("strobe %h", a), 1'b1, ok)
      `CHK($sformatf("byte %h", a), e, d)
   endtask : rchk
   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask : idle

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset;
      `CHK("irq pin", 1'b1, irq_pin_n)
      `CHK("page", 8'h00, upper_page)
      rchk(8'h02, 8'h15);
      rchk(8'h5f, 8'h00);
      rchk(8'h60, 8'h00);
      rchk(8'h69, 8'h00);
      rchk(8'h6a, 8'h00);
      engine_ready = 1'b1;
      idle(2);
      rchk(8'h02, 8'h14);
   endtask : t_reset
   task automatic t_los;
      signal_loss = 12'h801;
      idle(6);
      `CHK("irq pin", 1'b0, irq_pin_n)
      rchk(8'h06, 8'h40);
      rchk(8'h02, 8'h16);
      signal_loss = 12'h000;
      idle(6);
      rchk(8'h07, 8'h08);
      rchk(8'h08, 8'h01);
      rchk(8'h07, 8'h00);
      rchk(8'h06, 8'h00);
      `CHK("irq pin", 1'b1, irq_pin_n)
   endtask : t_los
   task automatic t_alarm;
      temp_high_cond = 1'b1;
      supply_low_cond = 1'b1;
      supply_high_cond = 1'b1;
      idle(1);
      temp_high_cond = 1'b0;
      supply_low_cond = 1'b0;
      supply_high_cond = 1'b0;
      temp_low_cond = 1'b1;
      idle(2);
      rchk(8'h06, 8'h02);
      rchk(8'h11, 8'hc0);
      rchk(8'h11, 8'h40);
      temp_low_cond = 1'b0;
      idle(1);
      rchk(8'h11, 8'h40);
      rchk(8'h11, 8'h00);
      rchk(8'h12, 8'hc0);
      rchk(8'h06, 8'h00);
   endtask : t_alarm
   task automatic t_mask;
      i_orx_host_model.wr(8'h69, 8'hff);
      rchk(8'h69, 8'hc0);
      temp_high_cond = 1'b1;
      idle(1);
      temp_high_cond = 1'b0;
      idle(2);
      `CHK("irq pin", 1'b1, irq_pin_n)
      i_orx_host_model.wr(8'h69, 8'h00);
      idle(2);
      `CHK("irq pin", 1'b0, irq_pin_n)
      rchk(8'h11, 8'h80);
   endtask : t_mask
   task automatic t_race;
      fork
         rchk(8'h11, 8'h00);
         begin
            @(negedge mclk);
            temp_high_cond = 1'b1;
            @(negedge mclk);
            temp_high_cond = 1'b0;
         end
      join
      rchk(8'h11, 8'h80);
   endtask : t_race
   task automatic t_ctrl;
      i_orx_host_model.wr(8'h7f, 8'h03);
      i_orx_host_model.wr(8'h02, 8'h00);
      i_orx_host_model.wr(8'h80, 8'h55);
      `CHK("page", 8'h03, upper_page)
      rchk(8'h02, 8'h14);
      rchk(8'h80, 8'hff);
      rchk(8'h16, 8'h2d);
      rchk(8'h1a, 8'h80);
      rchk(8'h1b, 8'he8);
      rchk(8'h26, 8'h01);
      rchk(8'h27, 8'h23);
      rchk(8'h6e, 8'h01);
      rchk(8'h6f, 8'h01);
      rchk(8'h74, 8'h06);
      i_orx_host_model.wr(8'h34, 8'h0a);
      i_orx_host_model.wr(8'h35, 8'h5c);
      i_orx_host_model.wr(8'h2a, 8'h01);
      i_orx_host_model.wr(8'h36, 8'h05);
      i_orx_host_model.wr(8'h37, 8'hc3);
      `CHK("chan off", 12'ha5c, channel_disable)
      `CHK("power", 1'b1, high_power_sel)
      `CHK("out off", 12'h5c3, output_disable)
      rchk(8'h36, 8'h05);
      for (k = 8'h77; k < 8'h7f; k++) i_orx_host_model.wr(k, k ^ 8'ha5);
      for (k = 8'h77; k < 8'h7f; k++) rchk(k, k ^ 8'ha5);
      i_orx_host_model.wr(8'h33, 8'h01);
      idle(1);
      `CHK("page", 8'h00, upper_page)
      `CHK("chan off", 12'h000, channel_disable)
      `CHK("power", 1'b0, high_power_sel)
      `CHK("out off", 12'h000, output_disable)
      rchk(8'h77, 8'h00);
   endtask : t_ctrl
   task automatic t_pin;
      temp_high_cond = 1'b1;
      i_orx_host_model.wr(8'h7f, 8'h03);
      temp_high_cond = 1'b0;
      idle(1);
      `CHK("irq pin", 1'b0, irq_pin_n)
      arst_n = 1'b0;
      idle(2);
      arst_n = 1'b1;
      `CHK("irq pin", 1'b1, irq_pin_n)
      `CHK("page", 8'h00, upper_page)
      rchk(8'h11, 8'h00);
   endtask : t_pin

   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // A hang past this many cycles counts as a mismatch
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         results;
      end
   end
   initial begin
      {temp_high_cond, temp_low_cond, supply_high_cond, supply_low_cond} = 4'h0;
      {arst_n, engine_ready, signal_loss} = 14'h0000;
      temp_value = 8'h2d;
      supply_value = 16'h80e8;
      elapsed_time = 16'h0123;
      idle(2);
      arst_n = 1'b1;
      t_reset;
      t_los;
      t_alarm;
      t_mask;
      t_race;
      t_ctrl;
      t_pin;
      results;
   end
endmodule : orx_lower_map_tb
